// ==== hw/tscw_slave.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "tscw_consts.svh"

module tscw_slave #(
  parameter int unsigned P_STARTUP_CYC = `TSCW_MS_TO_CYC(`TSCW_T_STARTUP_MS),
  parameter int unsigned P_SETUP_CYC = `TSCW_MS_TO_CYC(`TSCW_T_SETUP_MS),
  parameter int unsigned P_WIN_CYC = `TSCW_MS_TO_CYC(`TSCW_T_WIN_MS),
  parameter int unsigned P_HS_CYC = `TSCW_MS_TO_CYC(`TSCW_T_HS_MIN_MS)
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Serial bus, ready and supply pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_rdy,
  output logic o_rdy_o,
  output logic o_rdy_oe,
  input wire logic i_supply_pin,
  // Configuration
  input wire logic [6:0] i_slave_addr,
  input wire logic [7:0] i_ptr_default,
  input wire logic i_win_timed,
  input wire logic i_event_sel,
  // Conversion engine
  output logic o_conv_start,
  input wire logic i_conv_done,
  output logic o_converting,
  // Status
  output logic o_window_open,
  output logic o_setup_window,
  output logic o_event_mode,
  output logic o_mutual_sel,
  // Write stream
  output tscw_pkg::tscw_wr_t o_wr,
  output logic o_wr_valid,
  input wire logic i_wr_ready
);

  import tscw_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_b_s;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_b_s = rst_sync_r[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tscw_state_t r_r;
  tscw_state_t r_nxt;
  logic [3:0] pin_f;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic win_open;
  logic fifo_ready;
  logic in_map;
  logic ack;

  assign win_open = (r_r.win == TSCW_W_SETUP) || (r_r.win == TSCW_W_OPEN);

  always_comb begin
    r_nxt = r_r;
    r_nxt.conv_start = 1'b0;
    r_nxt.wr_push = 1'b0;
    ack = 1'b0;
    in_map = 1'b0;

    // Three-stage sampling; a level is taken once stages two and three agree
    r_nxt.sy1 = {i_supply_pin, i_rdy, i_sda, i_scl};
    r_nxt.sy2 = r_r.sy1;
    r_nxt.sy3 = r_r.sy2;
    pin_f = r_r.pin;
    for (int i = 0; i < 4; i++) begin
      if (r_r.sy2[i] == r_r.sy3[i]) begin
        pin_f[i] = r_r.sy3[i];
      end
    end
    r_nxt.pin = pin_f;

    scl_rise = !r_r.pin[`TSCW_PIN_SCL] && pin_f[`TSCW_PIN_SCL];
    scl_fall = r_r.pin[`TSCW_PIN_SCL] && !pin_f[`TSCW_PIN_SCL];
    start_c = r_r.pin[`TSCW_PIN_SCL] && pin_f[`TSCW_PIN_SCL] &&
      r_r.pin[`TSCW_PIN_SDA] && !pin_f[`TSCW_PIN_SDA];
    stop_c = r_r.pin[`TSCW_PIN_SCL] && pin_f[`TSCW_PIN_SCL] &&
      !r_r.pin[`TSCW_PIN_SDA] && pin_f[`TSCW_PIN_SDA];

    // --------------------------------------------------------------
    // Handshake watch: only counts while the device is not pulling ready
    // --------------------------------------------------------------
    if (!win_open) begin
      if (!pin_f[`TSCW_PIN_RDY]) begin
        if (r_r.hs_cnt != 20'hfffff) begin
          r_nxt.hs_cnt = r_r.hs_cnt + 20'h1;
        end
      end else begin
        r_nxt.hs_cnt = 20'h0;
        if (!r_r.pin[`TSCW_PIN_RDY] && r_r.hs_cnt >= 20'(P_HS_CYC)) begin
          r_nxt.hs_pend = 1'b1;
        end
      end
    end else begin
      r_nxt.hs_cnt = 20'h0;
    end

    // --------------------------------------------------------------
    // Serial engine
    // --------------------------------------------------------------
    if (start_c) begin
      // Repeated start keeps the window and begins a new operation
      r_nxt.bus = TSCW_B_RX;
      r_nxt.bit_cnt = 4'h0;
      r_nxt.byte_idx = 2'h0;
      r_nxt.sda_oe = 1'b0;
      if (win_open) begin
        r_nxt.xfer_seen = 1'b1;
      end
    end else if (stop_c) begin
      r_nxt.bus = TSCW_B_IDLE;
      r_nxt.sda_oe = 1'b0;
    end else begin
      case (r_r.bus)
        TSCW_B_RX: begin
          if (scl_rise) begin
            r_nxt.shreg = {r_r.shreg[6:0], pin_f[`TSCW_PIN_SDA]};
            r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
          end else if (scl_fall && r_r.bit_cnt == 4'h8) begin
            r_nxt.bit_cnt = 4'h0;
            if (r_r.byte_idx != 2'h2) begin
              r_nxt.byte_idx = r_r.byte_idx + 2'h1;
            end
            if (r_r.byte_idx == 2'h0) begin
              // Silent during conversions, so polling sees no answer
              ack = win_open && (r_r.shreg[7:1] == i_slave_addr);
              r_nxt.rw = r_r.shreg[0];
            end else if (r_r.byte_idx == 2'h1) begin
              ack = 1'b1;
              r_nxt.ptr = r_r.shreg;
            end else begin
              // Pointer runs past the last average word into a hole
              in_map = (r_r.ptr >= `TSCW_LTA_LO && r_r.ptr <= `TSCW_LTA_HI) ||
                (r_r.ptr >= `TSCW_SET_LO && r_r.ptr <= `TSCW_SET_HI);
              ack = 1'b1;
              if (r_r.ptr == `TSCW_MODE_ADDR) begin
                if (r_r.win == TSCW_W_SETUP) begin
                  r_nxt.mutual = r_r.shreg[`TSCW_MODE_BIT];
                end
              end else if (in_map) begin
                // A full queue refuses the byte rather than losing it
                ack = fifo_ready;
                r_nxt.wr_push = fifo_ready;
                r_nxt.wr = '{addr: r_r.ptr, data: r_r.shreg};
              end
              if (ack) begin
                r_nxt.ptr = r_r.ptr + 8'h1;
              end
            end
            r_nxt.sda_oe = ack;
            r_nxt.bus = ack ? TSCW_B_ACK : TSCW_B_SKIP;
          end
        end
        TSCW_B_ACK: begin
          if (scl_fall) begin
            r_nxt.sda_oe = 1'b0;
            // Reads are not served; the line floats high
            r_nxt.bus = r_r.rw ? TSCW_B_SKIP : TSCW_B_RX;
          end
        end
        TSCW_B_IDLE: begin
          r_nxt.sda_oe = 1'b0;
        end
        TSCW_B_SKIP: begin
          r_nxt.sda_oe = 1'b0;
        end
        default: begin
          r_nxt.bus = TSCW_B_IDLE;
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Window sequencing
    // --------------------------------------------------------------
    case (r_r.win)
      TSCW_W_POWER: begin
        if (r_r.pin[`TSCW_PIN_SUP]) begin
          r_nxt.tmr = r_r.tmr + 20'h1;
          if (r_r.tmr == 20'(P_STARTUP_CYC - 1)) begin
            r_nxt.win = TSCW_W_SETUP;
            r_nxt.tmr = 20'h0;
            r_nxt.xfer_seen = 1'b0;
            r_nxt.ptr = i_ptr_default;
          end
        end else begin
          r_nxt.tmr = 20'h0;
        end
      end
      TSCW_W_SETUP: begin
        if (stop_c) begin
          r_nxt.win = TSCW_W_CONV;
          r_nxt.conv_start = 1'b1;
        end else if (!r_r.xfer_seen && !start_c) begin
          r_nxt.tmr = r_r.tmr + 20'h1;
          if (r_r.tmr == 20'(P_SETUP_CYC - 1)) begin
            r_nxt.win = TSCW_W_CONV;
            r_nxt.evt = 1'b1;
            r_nxt.conv_start = 1'b1;
          end
        end
      end
      TSCW_W_CONV: begin
        r_nxt.tmr = 20'h0;
        if (i_conv_done) begin
          if ((r_r.evt || i_event_sel) && !r_r.hs_pend) begin
            // Event mode: only a handshake opens further windows
            r_nxt.win = TSCW_W_WAIT;
          end else begin
            r_nxt.win = TSCW_W_OPEN;
            r_nxt.hs_pend = 1'b0;
            r_nxt.xfer_seen = 1'b0;
            r_nxt.ptr = i_ptr_default;
          end
        end
      end
      TSCW_W_WAIT: begin
        r_nxt.tmr = 20'h0;
        if (r_r.hs_pend) begin
          r_nxt.win = TSCW_W_OPEN;
          r_nxt.hs_pend = 1'b0;
          r_nxt.xfer_seen = 1'b0;
          r_nxt.ptr = i_ptr_default;
        end
      end
      TSCW_W_OPEN: begin
        if (stop_c) begin
          r_nxt.win = TSCW_W_CONV;
          r_nxt.conv_start = 1'b1;
        end else if (i_win_timed && !r_r.xfer_seen && !start_c) begin
          r_nxt.tmr = r_r.tmr + 20'h1;
          if (r_r.tmr == 20'(P_WIN_CYC - 1)) begin
            r_nxt.win = TSCW_W_CONV;
            r_nxt.conv_start = 1'b1;
          end
        end
      end
      default: begin
        r_nxt.win = TSCW_W_POWER;
        r_nxt.tmr = 20'h0;
      end
    endcase

    // Supply loss restarts the power-up sequence
    if (!r_r.pin[`TSCW_PIN_SUP]) begin
      r_nxt.win = TSCW_W_POWER;
      r_nxt.evt = 1'b0;
      r_nxt.hs_pend = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_b_s) begin
    if (!rst_b_s) begin
      r_r <= '0;
      r_r.sy1 <= `TSCW_PIN_IDLE;
      r_r.sy2 <= `TSCW_PIN_IDLE;
      r_r.sy3 <= `TSCW_PIN_IDLE;
      r_r.pin <= `TSCW_PIN_IDLE;
      r_r.ptr <= `TSCW_PTR_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write queue
  // ----------------------------------------------------------------
  tscw_fifo #(
    .W($bits(tscw_wr_t)),
    .D(`TSCW_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_sys_clk),
    .i_rst_b(rst_b_s),
    .i_valid(r_r.wr_push),
    .o_ready(fifo_ready),
    .i_data(r_r.wr),
    .o_valid(o_wr_valid),
    .i_ready(i_wr_ready),
    .o_data(o_wr)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_sda_o = 1'b0;
  assign o_sda_oe = r_r.sda_oe;
  assign o_rdy_o = 1'b0;
  assign o_rdy_oe = win_open;
  assign o_conv_start = r_r.conv_start;
  assign o_converting = (r_r.win == TSCW_W_CONV);
  assign o_window_open = win_open;
  assign o_setup_window = (r_r.win == TSCW_W_SETUP);
  assign o_event_mode = r_r.evt;
  assign o_mutual_sel = r_r.mutual;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_b_s);

  rdy_follow_a: assert property ($rose(win_open) |-> o_rdy_oe ##1 (o_rdy_oe || !win_open))
    else $error("ready not pulled while window open");
  nack_conv_a: assert property ((r_r.bus == TSCW_B_RX) && (r_r.byte_idx == 2'h0) && !win_open
    |=> !o_sda_oe)
    else $error("acknowledge given outside window");
  stop_close_a: assert property (stop_c && win_open && r_r.pin[`TSCW_PIN_SUP]
    |=> o_conv_start && o_converting)
    else $error("stop did not close window");
  setup_tmo_a: assert property ((r_r.win == TSCW_W_SETUP) && r_r.pin[`TSCW_PIN_SUP] && !stop_c &&
    !start_c && !r_r.xfer_seen && (r_r.tmr == 20'(P_SETUP_CYC - 1))
    |=> o_event_mode && o_converting && !o_rdy_oe)
    else $error("setup window timeout wrong");
  startup_a: assert property ((r_r.win == TSCW_W_POWER) && r_r.pin[`TSCW_PIN_SUP] &&
    (r_r.tmr == 20'(P_STARTUP_CYC - 1)) |=> o_setup_window && o_rdy_oe)
    else $error("setup window did not open");
  ptr_load_a: assert property ($rose(win_open) |-> r_r.ptr == $past(i_ptr_default))
    else $error("pointer not loaded at window open");
  ptr_step_a: assert property (r_nxt.wr_push |=> r_r.ptr == $past(r_r.ptr) + 8'h1 ##1
    o_wr_valid)
    else $error("pointer did not advance on write");
  mode_lock_a: assert property (!o_setup_window |=> $stable(o_mutual_sel))
    else $error("mode changed outside setup window");
  write_dir_a: assert property (r_nxt.wr_push |-> !r_r.rw && r_r.byte_idx == 2'h2)
    else $error("write queued for a read transfer");
  win_tmo_a: assert property ((r_r.win == TSCW_W_OPEN) && !i_win_timed |=> o_window_open ||
    $past(stop_c) || !$past(r_r.pin[`TSCW_PIN_SUP]))
    else $error("untimed window closed without stop");

endmodule // tscw_slave

`default_nettype wire

// ==== hw/tscw_consts.svh ====
`ifndef TSCW_CONSTS_SVH
`define TSCW_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define TSCW_CLK_HZ 40000000
`define TSCW_T_STARTUP_MS 15
`define TSCW_T_SETUP_MS 22
`define TSCW_T_WIN_MS 2
`define TSCW_T_HS_MIN_MS 8
`define TSCW_MS_TO_CYC(ms) ((ms) * (`TSCW_CLK_HZ / 1000))

// ----------------------------------------------------------------
// Pin vector positions and idle levels
// ----------------------------------------------------------------
`define TSCW_PIN_SCL 0
`define TSCW_PIN_SDA 1
`define TSCW_PIN_RDY 2
`define TSCW_PIN_SUP 3
`define TSCW_PIN_IDLE 4'h7

// ----------------------------------------------------------------
// Memory map blocks
// ----------------------------------------------------------------
`define TSCW_LTA_LO 8'h30
`define TSCW_LTA_HI 8'h3f
`define TSCW_SET_LO 8'h48
`define TSCW_SET_HI 8'h5f
`define TSCW_MODE_ADDR 8'h48
`define TSCW_MODE_BIT 0

// ----------------------------------------------------------------
// Reset values and queue depth
// ----------------------------------------------------------------
`define TSCW_PTR_RST 8'h00
`define TSCW_FIFO_DEPTH 16

`endif

// ==== hw/tscw_pkg.sv ====
package tscw_pkg;

  // Window sequencing, Gray along power -> setup -> convert -> wait -> open
  typedef enum logic [2:0] {
    TSCW_W_POWER = 3'h0,
    TSCW_W_SETUP = 3'h1,
    TSCW_W_CONV = 3'h3,
    TSCW_W_WAIT = 3'h2,
    TSCW_W_OPEN = 3'h6
  } tscw_win_t;

  // Serial engine, Gray along idle -> receive -> acknowledge -> skip
  typedef enum logic [1:0] {
    TSCW_B_IDLE = 2'h0,
    TSCW_B_RX = 2'h1,
    TSCW_B_ACK = 2'h3,
    TSCW_B_SKIP = 2'h2
  } tscw_bus_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } tscw_wr_t;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [3:0] pin;
    tscw_win_t win;
    tscw_bus_t bus;
    logic [19:0] tmr;
    logic [19:0] hs_cnt;
    logic hs_pend;
    logic xfer_seen;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] ptr;
    logic sda_oe;
    logic conv_start;
    logic evt;
    logic mutual;
    tscw_wr_t wr;
    logic wr_push;
  } tscw_state_t;

endpackage

// ==== hw/tscw_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module tscw_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign o_ready = (cnt_r != (AW+1)'(D));
  assign o_valid = (cnt_r != '0);
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign o_data = mem_r[rp_r];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // tscw_fifo

`default_nettype wire

// ==== dv/tscw_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module tscw_host_model (
  // Clock and sensed data level
  input wire logic i_clk,
  input wire logic i_sda,
  // Pull-downs; a released line goes high by its pull-up
  output logic o_scl_low,
  output logic o_sda_low,
  output logic o_rdy_low
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_rdy_low = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus sequences, the clock stands still between frames
  // ----------------------------------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Also serves as repeated start when entered with the clock low
  task automatic start();
    o_sda_low = 1'b0;
    hold(4);
    o_scl_low = 1'b0;
    hold(4);
    o_sda_low = 1'b1;
    hold(4);
    o_scl_low = 1'b1;
    hold(2);
  endtask

  task automatic stop();
    o_sda_low = 1'b1;
    hold(2);
    o_scl_low = 1'b0;
    hold(4);
    o_sda_low = 1'b0;
    hold(1);
  endtask

  // Data moves only while the clock is low, never on the same edge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_low = ~b[i];
      hold(2);
      o_scl_low = 1'b0;
      hold(4);
      o_scl_low = 1'b1;
      hold(2);
    end
    o_sda_low = 1'b0;
    hold(4);
    o_scl_low = 1'b0;
    hold(2);
    ack = ~i_sda;
    hold(2);
    o_scl_low = 1'b1;
    hold(4);
  endtask

  task automatic handshake(input int n);
    o_rdy_low = 1'b1;
    hold(n);
    o_rdy_low = 1'b0;
    hold(1);
  endtask
endmodule  // tscw_host_model

`default_nettype wire

// ==== dv/tscw_slave_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "tscw_consts.svh"

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end

module tscw_slave_tb;
  import tscw_pkg::*;
  localparam int STUP = 40;
  localparam int SETUP = 200;
  localparam int WIN = 100;
  localparam int HS = 30;

  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_supply_pin = 1'b0;
  logic [6:0] i_slave_addr = 7'h00;
  logic [7:0] i_ptr_default = 8'h00;
  logic i_win_timed = 1'b0;
  logic i_conv_done = 1'b0;
  logic i_event_sel = 1'b0;
  logic i_wr_ready = 1'b0;
  logic o_sda_o, o_sda_oe, o_rdy_o, o_rdy_oe, o_conv_start, o_converting;
  logic o_window_open, o_setup_window, o_event_mode, o_mutual_sel, o_wr_valid;
  logic scl_low, sda_low, rdy_low, scl, sda, rdy, a;
  tscw_wr_t o_wr;
  tscw_wr_t exp_q[$];
  int n_fail = 0;
  int checks_done = 0;
  int cnt = 0;
  int n;
  logic [31:0] seed = 32'h6fbb;
  logic [7:0] ptr;

  // Open-drain wires with pull-ups
  assign scl = ~scl_low;
  assign sda = ~(sda_low | (o_sda_oe & ~o_sda_o));
  assign rdy = ~(rdy_low | (o_rdy_oe & ~o_rdy_o));

  always #12.5 i_sys_clk = ~i_sys_clk;

  tscw_slave #(.P_STARTUP_CYC(STUP), .P_SETUP_CYC(SETUP), .P_WIN_CYC(WIN),
    .P_HS_CYC(HS)) u_tscw_slave (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_scl(scl), .i_sda(sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .i_rdy(rdy), .o_rdy_o(o_rdy_o), .o_rdy_oe(o_rdy_oe),
    .i_supply_pin(i_supply_pin), .i_slave_addr(i_slave_addr),
    .i_ptr_default(i_ptr_default), .i_win_timed(i_win_timed),
    .i_event_sel(i_event_sel), .o_conv_start(o_conv_start), .i_conv_done(i_conv_done),
    .o_converting(o_converting), .o_window_open(o_window_open),
    .o_setup_window(o_setup_window), .o_event_mode(o_event_mode),
    .o_mutual_sel(o_mutual_sel), .o_wr(o_wr), .o_wr_valid(o_wr_valid),
    .i_wr_ready(i_wr_ready));

  tscw_host_model u_tscw_host_model (.i_clk(i_sys_clk), .i_sda(sda),
    .o_scl_low(scl_low), .o_sda_low(sda_low), .o_rdy_low(rdy_low));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic in_map(input logic [7:0] p);
    return (p >= `TSCW_LTA_LO && p <= `TSCW_LTA_HI) ||
      (p >= `TSCW_SET_LO && p <= `TSCW_SET_HI && p != `TSCW_MODE_ADDR);
  endfunction

  // Conversion engine stand-in with a random busy time
  always @(posedge i_sys_clk) begin
    #1;
    i_conv_done = (cnt == 1);
    if (o_conv_start === 1'b1) cnt = 250 + int'(xs() % 64);
    else if (cnt > 0) cnt--;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic wait_rdy(input logic v, input int lim, output int k);
    for (k = 0; k < lim && o_rdy_oe !== v; k++) tick();
    if (o_rdy_oe !== v) begin
      n_fail++;
      $display("[FAIL] t=%0t got %0h exp %0h", $time, o_rdy_oe, v);
      wrap_up();
    end
  endtask

  task automatic up_window();
    wait_rdy(1'b1, STUP + 30, n);
    `CHK(n >= STUP && n <= STUP + 10, 1'b1)
    `CHK(o_setup_window, 1'b1)
  endtask

  task automatic poll(input logic [6:0] ad);
    u_tscw_host_model.start();
    u_tscw_host_model.send_byte({ad, 1'b0}, a);
  endtask

  // Pointer once, then data; a full queue refuses in-map bytes
  task automatic xfer(input logic [7:0] p, input int cnt_b);
    logic [7:0] d;
    logic e;
    poll(i_slave_addr);
    `CHK(a, 1'b1)
    u_tscw_host_model.send_byte(p, a);
    ptr = p;
    repeat (cnt_b) begin
      d = 8'(xs()) | 8'h01;
      e = !(in_map(ptr) && exp_q.size() >= `TSCW_FIFO_DEPTH);
      u_tscw_host_model.send_byte(d, a);
      `CHK(a, e)
      if (e && in_map(ptr)) exp_q.push_back({ptr, d});
      if (e) ptr++;
    end
  endtask

  task automatic close_chk();
    u_tscw_host_model.stop();
    for (int k = 0; k < 20 && o_conv_start !== 1'b1; k++) tick();
    `CHK(o_conv_start, 1'b1)
    tick();
    `CHK({o_rdy_oe, o_window_open, o_converting}, 3'b001)
  endtask

  // Consumer stalls at random while the queue drains
  task automatic drain();
    tscw_wr_t e;
    for (int k = 0; k < 2000 && exp_q.size() > 0; k++) begin
      @(posedge i_sys_clk);
      if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
        e = exp_q.pop_front();
        `CHK(o_wr, e)
      end
      #1;
      i_wr_ready = (xs() % 3) != 0;
    end
    i_wr_ready = 1'b0;
    tick();
    `CHK(exp_q.size(), 0)
    `CHK(o_wr_valid, 1'b0)
  endtask

  initial begin
    #2_000_000;
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    i_slave_addr = 7'(xs());
    i_ptr_default = 8'(xs());
    repeat (20) @(posedge i_sys_clk);
    #1;
    i_rst_b = 1'b1;
    i_supply_pin = 1'b1;
    up_window();
    wait_rdy(1'b0, SETUP + 30, n);
    `CHK(n >= SETUP - 2 && n <= SETUP + 10, 1'b1)
    `CHK({o_event_mode, o_converting}, 2'b11)
    for (int k = 0; k < 400 && o_converting !== 1'b0; k++) tick();
    repeat (20) tick();
    `CHK(o_rdy_oe, 1'b0)
    poll(i_slave_addr);
    `CHK(a, 1'b0)
    u_tscw_host_model.stop();
    u_tscw_host_model.handshake(HS + 10);
    wait_rdy(1'b1, 400, n);
    xfer(`TSCW_MODE_ADDR, 18);
    close_chk();
    `CHK(o_mutual_sel, 1'b0)
    drain();
    $display("test event window and queue fill done");
    i_supply_pin = 1'b0;
    repeat (10) tick();
    `CHK(o_rdy_oe, 1'b0)
    i_supply_pin = 1'b1;
    i_win_timed = 1'b1;
    up_window();
    `CHK(o_event_mode, 1'b0)
    poll(i_slave_addr ^ 7'h01);
    `CHK(a, 1'b0)
    xfer(`TSCW_MODE_ADDR, 1);
    xfer(8'h3e, 3);
    close_chk();
    `CHK(o_mutual_sel, 1'b1)
    poll(i_slave_addr);
    `CHK(a, 1'b0)
    u_tscw_host_model.stop();
    wait_rdy(1'b1, 400, n);
    `CHK(o_setup_window, 1'b0)
    wait_rdy(1'b0, WIN + 30, n);
    `CHK(n >= WIN - 2 && n <= WIN + 10, 1'b1)
    // Selected event mode: the conversion ends without a window
    i_event_sel = 1'b1;
    drain();
    for (int k = 0; k < 400 && o_converting !== 1'b0; k++) tick();
    repeat (20) tick();
    `CHK({o_rdy_oe, o_converting}, 2'b00)
    $display("test setup window and timed window done");
    wrap_up();
  end
endmodule  // tscw_slave_tb

`default_nettype wire
